// ---- rtl/sddc_top.sv ----
// module: control and status logic of the on-chip low-supply detector
//
// Contract
// - stable flag is read-only control bit 5
// - power enable bit powers the monitor
// - decode level: 0 reserved, 1-14 taps, 15 external
// - spurious flag during settle; software clears it; the code counts no trip before SDDC_READY, so no flag is raised while settling
// - every enable passes a stabilization interval
// - supply below trip sets interrupt flag
// - code 15 routes external input to comparator
// - monitor runs in sleep; trip wakes device
// - reset returns control register, monitor off
//
// The address-and-strobe port and the register addresses were left to the implementer.
module sddc_top #(
	parameter int SETTLE_CYC = sddc_pkg::SDDC_SETTLE_CYC
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_cmp_trip,
	input wire logic i_sleep,
	output logic [7:0] o_rdata,
	output logic o_mon_power,
	output logic [13:0] o_tap_sel,
	output logic o_ext_sel,
	output logic o_cpu_int,
	output logic o_wake,
	output logic o_irq
);
	import sddc_pkg::*;

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [3:0] level_reg;
	logic pwr_en_reg;
	logic stable_reg;
	logic int_flag_reg;
	logic int_en_reg;
	logic gie_reg;
	logic [SDDC_EV_WIDTH-1:0] status_reg;
	logic [SDDC_EV_WIDTH-1:0] mask_reg;
	sddc_state_t state_reg;
	sddc_state_t state_next;
	logic settle_done;
	logic level_valid;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire wr_ctrl = i_wr && (i_addr == SDDC_OFF_CONTROL);
	wire wr_mask = i_wr && (i_addr == SDDC_OFF_MASK);
	wire wr_irqc = i_wr && (i_addr == SDDC_OFF_IRQCTL);
	wire rd_stat = i_rd && (i_addr == SDDC_OFF_STATUS);
	wire [7:0] wdata_ctrl = i_wdata & SDDC_CTRL_WMASK;
	wire en_rise = wr_ctrl && wdata_ctrl[SDDC_BIT_PWR_EN] && !pwr_en_reg;
	wire en_fall = wr_ctrl && !wdata_ctrl[SDDC_BIT_PWR_EN];

	// a trip only counts once the reference is stable and a level is legal
	wire trip_event = state_reg == SDDC_READY && i_cmp_trip && level_valid;
	wire stable_event = settle_done;
	wire [SDDC_EV_WIDTH-1:0] ev_vec = {stable_event, trip_event};
	wire clr_flag = wr_irqc && i_wdata[SDDC_BIT_INT_FLAG];

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire [7:0] ctrl_view = {2'b00, stable_reg, pwr_en_reg, level_reg};
	wire [7:0] stat_view = {{(8-SDDC_EV_WIDTH){1'b0}}, status_reg};
	wire [7:0] mask_view = {{(8-SDDC_EV_WIDTH){1'b0}}, mask_reg};
	wire [7:0] irqc_view = {5'b00000, int_flag_reg, gie_reg, int_en_reg};
	wire [7:0] rd_mux = (i_addr == SDDC_OFF_CONTROL) ? ctrl_view :
		(i_addr == SDDC_OFF_STATUS) ? stat_view :
		(i_addr == SDDC_OFF_MASK) ? mask_view :
		(i_addr == SDDC_OFF_IRQCTL) ? irqc_view : 8'h00;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	sddc_settle_timer #(
		.CNT_W(SDDC_CNT_W)
	) sddc_settle_timer_i (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_start(en_rise),
		.i_abort(en_fall),
		.i_count(SDDC_CNT_W'(SETTLE_CYC)),
		.o_done(settle_done)
	);

	sddc_level_decode sddc_level_decode_i (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_level(level_reg),
		.o_tap_sel(o_tap_sel),
		.o_ext_sel(o_ext_sel),
		.o_level_valid(level_valid)
	);

	// ------------------------------------------------------------
	// settle sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SDDC_OFF: begin
				if (en_rise) state_next = SDDC_SETTLING;
			end
			SDDC_SETTLING: begin
				if (en_fall) state_next = SDDC_OFF;
				else if (settle_done) state_next = SDDC_READY;
			end
			SDDC_READY: begin
				if (en_fall) state_next = SDDC_OFF;
			end
		endcase
	end

	// control register; reset turns the monitor off
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			level_reg <= SDDC_LVL_RESET;
			pwr_en_reg <= 1'b0;
			state_reg <= SDDC_OFF;
		end else begin
			state_reg <= state_next;
			if (wr_ctrl) begin
				level_reg <= wdata_ctrl[SDDC_LVL_MSB:0];
				pwr_en_reg <= wdata_ctrl[SDDC_BIT_PWR_EN];
			end
		end
	end

	// stable flag follows the sequencer, never set while disabled
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			stable_reg <= 1'b0;
		end else begin
			stable_reg <= (state_next == SDDC_READY);
		end
	end

	// interrupt flag: hardware set beats a software clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			int_flag_reg <= 1'b0;
			int_en_reg <= 1'b0;
			gie_reg <= 1'b0;
		end else begin
			if (trip_event) int_flag_reg <= 1'b1;
			else if (clr_flag) int_flag_reg <= 1'b0;
			if (wr_irqc) begin
				int_en_reg <= i_wdata[SDDC_BIT_INT_EN];
				gie_reg <= i_wdata[SDDC_BIT_GIE];
			end
		end
	end

	// sticky status, read clears; new events win over the clear
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			status_reg <= '0;
			mask_reg <= '0;
		end else begin
			status_reg <= (rd_stat ? '0 : status_reg) | ev_vec;
			if (wr_mask) mask_reg <= i_wdata[SDDC_EV_WIDTH-1:0];
		end
	end

	// ------------------------------------------------------------
	// outputs, all registered
	// ------------------------------------------------------------
	wire flag_next = trip_event || (int_flag_reg && !clr_flag);
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
			o_mon_power <= 1'b0;
			o_cpu_int <= 1'b0;
			o_wake <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_mux : 8'h00;
			o_mon_power <= (state_next != SDDC_OFF);
			o_cpu_int <= flag_next && int_en_reg && gie_reg;
			// wake does not need the global enable; sleep keeps the monitor alive
			o_wake <= i_sleep && flag_next && int_en_reg;
			o_irq <= |(((rd_stat ? '0 : status_reg) | ev_vec) & mask_reg);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_stable_off_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!o_mon_power |-> !stable_reg) else $error("stable flag set while off");
	a_stable_after_settle: assert property (@(posedge i_clk) disable iff (!i_resetn)
		en_rise |=> !stable_reg [*2]) else $error("stable flag too early");
	a_power_follows_en: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_ctrl |=> o_mon_power == $past(wdata_ctrl[SDDC_BIT_PWR_EN]))
		else $error("power does not follow enable");
	a_trip_sets_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
		trip_event |=> int_flag_reg) else $error("trip lost");
	a_clear_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
		clr_flag && !trip_event |=> !int_flag_reg) else $error("flag not cleared");
	a_high_bits_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$past(i_rd) && $past(i_addr) == SDDC_OFF_CONTROL |-> o_rdata[7:6] == 2'b00)
		else $error("reserved bits nonzero");
	a_ext_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
		level_reg == SDDC_LVL_EXTERNAL |=> o_ext_sel && o_tap_sel == 14'h0000)
		else $error("external source not routed");
	a_reset_off: assert property (@(posedge i_clk)
		!i_resetn |=> !pwr_en_reg && !o_mon_power) else $error("reset left monitor on");
	a_wake_sleep: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_sleep && trip_event && int_en_reg |=> o_wake) else $error("no wake on trip");
	a_stable_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$past(i_rd) && $past(i_addr) == SDDC_OFF_CONTROL |-> o_rdata[5] == $past(stable_reg))
		else $error("stable bit read wrong");
	a_level_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
		level_reg == 4'h3 |=> o_tap_sel == 14'h0004 && level_valid)
		else $error("tap decode wrong");
endmodule

// ---- rtl/sddc_pkg.sv ----
// package: register map, field positions, reset values and timing for the supply monitor control
package sddc_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] SDDC_OFF_CONTROL = 4'h0; // supply_monitor_control
	localparam logic [3:0] SDDC_OFF_STATUS = 4'h1; // sticky event status, read clears
	localparam logic [3:0] SDDC_OFF_MASK = 4'h2; // event mask, same layout as status
	localparam logic [3:0] SDDC_OFF_IRQCTL = 4'h3; // int enable and global enable
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int SDDC_BIT_STABLE = 5;
	localparam int SDDC_BIT_PWR_EN = 4;
	localparam int SDDC_LVL_MSB = 3;
	localparam logic [3:0] SDDC_LVL_RESERVED = 4'h0;
	localparam logic [3:0] SDDC_LVL_EXTERNAL = 4'hf;
	localparam logic [3:0] SDDC_LVL_RESET = 4'h5;
	localparam logic [7:0] SDDC_CTRL_WMASK = 8'h1f;
	// ------------------------------------------------------------
	// status / mask fields and irq control fields
	// ------------------------------------------------------------
	localparam int SDDC_EV_TRIP = 0; // low-supply trip seen
	localparam int SDDC_EV_STABLE = 1; // reference became stable
	localparam int SDDC_EV_WIDTH = 2;
	localparam int SDDC_BIT_INT_EN = 0; // low_supply_int_enable
	localparam int SDDC_BIT_GIE = 1; // global_int_enable
	localparam int SDDC_BIT_INT_FLAG = 2; // low_supply_int_flag, write 1 clears
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SDDC_CLK_HZ = 25000000;
	localparam int SDDC_SETTLE_US = 20; // stabilization interval, plain default
	localparam int SDDC_SETTLE_CYC = (SDDC_SETTLE_US * (SDDC_CLK_HZ / 1000000) < 1) ? 1 :
		SDDC_SETTLE_US * (SDDC_CLK_HZ / 1000000);
	localparam int SDDC_CNT_W = 16;
	// ------------------------------------------------------------
	// settle sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SDDC_OFF, SDDC_SETTLING, SDDC_READY} sddc_state_t;
endpackage

// ---- rtl/sddc_settle_timer.sv ----
// module: down counter that measures the stabilization interval after an enable
module sddc_settle_timer #(
	parameter int CNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [CNT_W-1:0] i_count,
	output logic o_done
);
	import sddc_pkg::*;
	logic [CNT_W-1:0] cnt_reg;
	logic run_reg;
	wire last_tick = run_reg && (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
	// restart on every enable; abort on disable so a stale count never finishes
	always_ff @(posedge i_clk) begin
		if (!i_resetn || i_abort) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			o_done <= 1'b0;
		end else if (i_start) begin
			cnt_reg <= i_count;
			run_reg <= 1'b1;
			o_done <= 1'b0;
		end else begin
			o_done <= last_tick;
			if (run_reg) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
			if (last_tick) begin
				run_reg <= 1'b0;
			end
		end
	end
endmodule

// ---- rtl/sddc_level_decode.sv ----
// module: decodes the trip-level select into a one-hot tap select and a source select
module sddc_level_decode (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [3:0] i_level,
	output logic [13:0] o_tap_sel,
	output logic o_ext_sel,
	output logic o_level_valid
);
	import sddc_pkg::*;
	wire is_ext = (i_level == SDDC_LVL_EXTERNAL);
	wire is_rsv = (i_level == SDDC_LVL_RESERVED);
	logic [13:0] tap_next;
	// codes 1..14 each light one internal tap
	genvar g;
	generate
		for (g = 0; g < 14; g++) begin : gen_tap
			assign tap_next[g] = (i_level == 4'(g + 1));
		end
	endgenerate
	// registered so the analog mux sees glitch-free selects
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_tap_sel <= '0;
			o_ext_sel <= 1'b0;
			o_level_valid <= 1'b0;
		end else begin
			o_tap_sel <= tap_next;
			o_ext_sel <= is_ext;
			o_level_valid <= !is_rsv;
		end
	end
endmodule

// ---- verification/supply_drop_detect_ctrl_test.sv ----
// testbench: register-level checks of the supply monitor control block
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

module supply_drop_detect_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sddc_pkg::*;

	// ------------------------------------------------------------
	// signals and design instance
	// ------------------------------------------------------------
	localparam int SIM_SETTLE = 8; // short settle keeps the run brief
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_cmp_trip = 1'b0;
	logic i_sleep = 1'b0;
	logic [7:0] o_rdata;
	logic o_mon_power;
	logic [13:0] o_tap_sel;
	logic o_ext_sel;
	logic o_cpu_int;
	logic o_wake;
	logic o_irq;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] rd_val;

	sddc_top #(.SETTLE_CYC(SIM_SETTLE)) sddc_top_i (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_cmp_trip(i_cmp_trip), .i_sleep(i_sleep),
		.o_rdata(o_rdata), .o_mon_power(o_mon_power), .o_tap_sel(o_tap_sel),
		.o_ext_sel(o_ext_sel), .o_cpu_int(o_cpu_int), .o_wake(o_wake), .o_irq(o_irq)
	);

	// clock and hang guard; the ceiling is far above the expected run of under two hundred cycles
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	// each access starts on its own edge, so a strobe is never driven twice in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		// reset state: level 5, monitor off, nothing pending
		rd_chk(SDDC_OFF_CONTROL, 8'h05);
		`CHK(o_mon_power, 1'b0)
		`CHK(o_tap_sel, 14'h0010)
		rd_chk(SDDC_OFF_STATUS, 8'h00);
		rd_chk(SDDC_OFF_IRQCTL, 8'h00);
		// top bits and the stable flag ignore writes; code 15 picks the external pin
		wr(SDDC_OFF_CONTROL, 8'hef);
		rd_chk(SDDC_OFF_CONTROL, 8'h0f);
		`CHK(o_ext_sel, 1'b1)
		`CHK(o_tap_sel, 14'h0000)
		// every internal code drives exactly its own tap; code 0 drives none
		for (int k = 0; k < 15; k++) begin
			wr(SDDC_OFF_CONTROL, 8'(k));
			wait_cyc(2);
			`CHK(o_tap_sel, (k == 0) ? 14'h0000 : 14'(14'h0001 << (k - 1)))
			`CHK(o_ext_sel, 1'b0)
		end
		// setup order: level, interrupt off, unmask stable event, enable
		wr(SDDC_OFF_CONTROL, 8'h03);
		wr(SDDC_OFF_IRQCTL, 8'h00);
		wr(SDDC_OFF_MASK, 8'h02);
		wr(SDDC_OFF_CONTROL, 8'h13);
		`CHK(o_mon_power, 1'b1)
		rd_chk(SDDC_OFF_CONTROL, 8'h13);
		rd_val = 8'h00;
		for (int n = 0; n < 30 && rd_val[5] !== 1'b1; n++) begin
			rd(SDDC_OFF_CONTROL, rd_val);
		end
		`CHK(rd_val, 8'h33)
		// clear any flag left from settling; none may have been raised
		wr(SDDC_OFF_IRQCTL, 8'h04);
		rd_chk(SDDC_OFF_IRQCTL, 8'h00);
		// stable event is sticky, unmasked, and cleared by reading
		`CHK(o_irq, 1'b1)
		rd_chk(SDDC_OFF_STATUS, 8'h02);
		wait_cyc(2);
		`CHK(o_irq, 1'b0)
		// trip with the event masked and interrupts off
		wr(SDDC_OFF_MASK, 8'h00);
		@(posedge i_clk);
		i_cmp_trip <= 1'b1;
		wait_cyc(3);
		`CHK(o_irq, 1'b0)
		`CHK(o_cpu_int, 1'b0)
		rd_chk(SDDC_OFF_IRQCTL, 8'h04);
		@(posedge i_clk);
		i_cmp_trip <= 1'b0;
		wr(SDDC_OFF_IRQCTL, 8'h04);
		rd_chk(SDDC_OFF_IRQCTL, 8'h00);
		wr(SDDC_OFF_MASK, 8'h01);
		wait_cyc(2);
		`CHK(o_irq, 1'b1)
		rd_chk(SDDC_OFF_STATUS, 8'h01);
		wait_cyc(2);
		`CHK(o_irq, 1'b0)
		// interrupts enabled last; a trip in sleep interrupts and wakes
		wr(SDDC_OFF_IRQCTL, 8'h03);
		@(posedge i_clk);
		i_sleep <= 1'b1;
		i_cmp_trip <= 1'b1;
		wait_cyc(3);
		`CHK(o_cpu_int, 1'b1)
		`CHK(o_wake, 1'b1)
		@(posedge i_clk);
		i_cmp_trip <= 1'b0;
		wr(SDDC_OFF_IRQCTL, 8'h07);
		wait_cyc(2);
		`CHK(o_cpu_int, 1'b0)
		`CHK(o_wake, 1'b0)
		@(posedge i_clk);
		i_sleep <= 1'b0;
		// short check period over: power down drops the stable flag
		wr(SDDC_OFF_CONTROL, 8'h03);
		`CHK(o_mon_power, 1'b0)
		rd_chk(SDDC_OFF_CONTROL, 8'h03);
		// unmapped address reads zero and leaves the control register alone
		wr(4'hf, 8'hff);
		rd_chk(4'hf, 8'h00);
		rd_chk(SDDC_OFF_CONTROL, 8'h03);
		// reset in mid-run turns a running monitor off and drops the pending trip event
		wr(SDDC_OFF_CONTROL, 8'h1a);
		`CHK(o_mon_power, 1'b1)
		`CHK(o_irq, 1'b1)
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		`CHK(o_mon_power, 1'b0)
		`CHK(o_irq, 1'b0)
		rd_chk(SDDC_OFF_CONTROL, 8'h05);
		rd_chk(SDDC_OFF_MASK, 8'h00);
		tally_and_finish();
	end
endmodule
